// ==== hw/phase_input_filter.sv ====
// Digital noise filter for one synchronised phase input
`timescale 1ns/1ns
module phase_input_filter #(
  parameter int FILT_LEN = quadrature_phase_counter_pkg::FILT_LEN_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic en,
  input wire logic d,
  output logic q
);

  localparam int CW = $clog2(FILT_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

  logic stable_q;
  logic [CW-1:0] run_q;
  logic differs;

  assign differs = d != stable_q;
  // Bypass when the filter is disabled
  assign q = en ? stable_q : d;

  ////////////////////////////////////////////////////////////////////////////
  // New level is taken after FILT_LEN equal samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable_q <= 1'b0;
      run_q <= '0;
    end
    else if (clr)
    begin
      stable_q <= d;
      run_q <= '0;
    end
    else if (!differs)
      run_q <= '0;
    else if (run_q == LAST)
    begin
      stable_q <= d;
      run_q <= '0;
    end
    else
      run_q <= run_q + CW'(1);
  end

endmodule // phase_input_filter

// ==== hw/phase_step_decode.sv ====
// Edge and level decode of the two phase inputs into one step
`timescale 1ns/1ns
module phase_step_decode (
  input quadrature_phase_counter_pkg::phase_pair_t prev,
  input quadrature_phase_counter_pkg::phase_pair_t cur,
  input wire logic [7:0] cond_en,
  output logic [7:0] events,
  output quadrature_phase_counter_pkg::step_t step
);

  logic a_rise, a_fall, b_rise, b_fall;
  logic inc_any, dec_any;

  assign a_rise = cur.a & ~prev.a;
  assign a_fall = ~cur.a & prev.a;
  assign b_rise = cur.b & ~prev.b;
  assign b_fall = ~cur.b & prev.b;

  ////////////////////////////////////////////////////////////////////////////
  // Increment conditions, level taken before the edge
  assign events[7] = b_rise & ~prev.a;
  assign events[6] = a_rise & prev.b;
  assign events[5] = b_fall & prev.a;
  assign events[4] = a_fall & ~prev.b;
  // Decrement conditions
  assign events[3] = a_fall & prev.b;
  assign events[2] = b_fall & ~prev.a;
  assign events[1] = a_rise & ~prev.b;
  assign events[0] = b_rise & prev.a;

  // Each condition gated by its own enable
  assign inc_any = |(events[7:4] & cond_en[7:4]); // RULE2 RULE4
  assign dec_any = |(events[3:0] & cond_en[3:0]); // RULE3 RULE4
  // Opposing steps in one cycle cancel
  assign step.inc = inc_any & ~dec_any; // RULE12
  assign step.dec = dec_any & ~inc_any; // RULE12

endmodule // phase_step_decode

// ==== hw/quadrature_phase_counter.sv ====
// Quadrature phase counter with APB registers and interrupt
// What this block does
// RULE1 - Counts up or down from the phase relation of inputs A and B, never a clock
// RULE2 - Adds one on B rise/A low, A rise/B high, B fall/A high, A fall/B low
// RULE3 - Subtracts one on A fall/B high, B fall/A low, A rise/B low, B rise/A high
// RULE4 - Eight enable bits gate the events; bits 7..4 up, bits 3..0 down
// RULE5 - A clear source setting leaves the counter never cleared automatically
// RULE6 - Each phase input has a digital filter that software can bypass
// RULE7 - Software may write a start value into the counter before counting
// RULE8 - Upward wrap raises overflow, downward wrap underflow, each with an enable
// RULE9 - Gate bit low holds the timer in reset and ignores its register writes
// RULE10 - Run bit 7 of the mode register stops at 0 and counts at 1
// RULE11 - An enabled overflow or underflow sets the request flag until software clears it
// RULE12 - Inputs are synchronised, edges found by comparing samples, one step per cycle
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module quadrature_phase_counter #(
  parameter int CNT_W = 16,
  parameter int FILT_LEN = quadrature_phase_counter_pkg::FILT_LEN_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_input_a,
  input wire logic phase_input_b,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic gate_q;
  logic [7:0] mode_q;
  logic [7:0] count_condition_enable_q;
  logic [CNT_W-1:0] up_down_counter_q, up_down_counter_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q;
  logic timer_irq_request_flag_q, flag_d;
  logic [31:0] prdata_q, rd_mux;
  logic pslverr_q;
  quadrature_phase_counter_pkg::phase_pair_t sync1_q, sync2_q, filt, prev_q;
  quadrature_phase_counter_pkg::step_t step;
  quadrature_phase_counter_pkg::clr_sel_t clr_sel;
  logic [7:0] events;
  logic [1:0] filt_en;
  logic timer_rst, run, wr_acc, rd_setup, mapped;
  logic hit_gate, hit_mode, hit_cond, hit_cnt, hit_stat, hit_mask, hit_flag;
  logic wr_mode, wr_cond, wr_cnt, wr_stat, wr_mask, wr_flag;
  logic auto_clr, do_inc, do_dec, ovf, udf;
  logic [1:0] stat_set;
  logic flag_set;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign hit_gate = paddr == quadrature_phase_counter_pkg::OFS_GATE;
  assign hit_mode = paddr == quadrature_phase_counter_pkg::OFS_MODE;
  assign hit_cond = paddr == quadrature_phase_counter_pkg::OFS_COND;
  assign hit_cnt = paddr == quadrature_phase_counter_pkg::OFS_CNT;
  assign hit_stat = paddr == quadrature_phase_counter_pkg::OFS_STAT;
  assign hit_mask = paddr == quadrature_phase_counter_pkg::OFS_MASK;
  assign hit_flag = paddr == quadrature_phase_counter_pkg::OFS_FLAG;
  assign mapped = hit_gate | hit_mode | hit_cond | hit_cnt | hit_stat | hit_mask | hit_flag;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable;
  // Timer registers take writes only while the clock gate is set
  assign wr_mode = wr_acc & hit_mode & gate_q; // RULE9
  assign wr_cond = wr_acc & hit_cond & gate_q;
  assign wr_cnt = wr_acc & hit_cnt & gate_q;
  assign wr_stat = wr_acc & hit_stat & gate_q;
  assign wr_mask = wr_acc & hit_mask & gate_q;
  assign wr_flag = wr_acc & hit_flag & gate_q;

  // Read data, timer registers read as zero while gated off
  assign rd_mux = hit_gate ? {31'h0, gate_q} :
                  !gate_q ? 32'h0 :
                  hit_mode ? {24'h0, mode_q} :
                  hit_cond ? {24'h0, count_condition_enable_q} :
                  hit_cnt ? 32'(up_down_counter_q) :
                  hit_stat ? {30'h0, stat_q} :
                  hit_mask ? {30'h0, mask_q} :
                  hit_flag ? {31'h0, timer_irq_request_flag_q} : 32'h0;

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata_q <= pwrite ? 32'h0 : rd_mux;
      pslverr_q <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gate register, never itself held in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_q <= 1'b0;
    else if (wr_acc & hit_gate)
      gate_q <= pwdata[quadrature_phase_counter_pkg::GATE_BIT];
  end

  assign timer_rst = ~gate_q; // RULE9

  ////////////////////////////////////////////////////////////////////////////
  // Mode and condition enable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= quadrature_phase_counter_pkg::MODE_RST;
      count_condition_enable_q <= quadrature_phase_counter_pkg::COND_RST;
      mask_q <= quadrature_phase_counter_pkg::MASK_RST;
    end
    else if (timer_rst)
    begin
      mode_q <= quadrature_phase_counter_pkg::MODE_RST; // RULE9
      count_condition_enable_q <= quadrature_phase_counter_pkg::COND_RST;
      mask_q <= quadrature_phase_counter_pkg::MASK_RST;
    end
    else
    begin
      if (wr_mode)
        mode_q <= pwdata[7:0];
      if (wr_cond)
        count_condition_enable_q <= pwdata[7:0]; // RULE4
      if (wr_mask)
        mask_q <= pwdata[1:0]; // RULE8
    end
  end

  assign run = mode_q[quadrature_phase_counter_pkg::MODE_RUN_BIT]; // RULE10
  assign clr_sel = quadrature_phase_counter_pkg::clr_sel_t'(
    mode_q[quadrature_phase_counter_pkg::MODE_CLR_HI:quadrature_phase_counter_pkg::MODE_CLR_LO]);
  assign filt_en = {mode_q[quadrature_phase_counter_pkg::MODE_FILT_B_BIT],
                    mode_q[quadrature_phase_counter_pkg::MODE_FILT_A_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser of the phase pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {phase_input_b, phase_input_a}; // RULE12
      sync2_q <= sync1_q;
    end
  end

  // Optional filter per input
  for (genvar i = 0; i < 2; i++)
  begin : g_filt
    phase_input_filter #(
      .FILT_LEN(FILT_LEN)
    ) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(timer_rst),
      .en(filt_en[i]), // RULE6
      .d(sync2_q[i]),
      .q(filt[i])
    );
  end

  // Previous sample for edge detection, tracked even while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_q <= '0;
    else
      prev_q <= filt; // RULE12
  end

  phase_step_decode u_dec (
    .prev(prev_q),
    .cur(timer_rst ? prev_q : filt),
    .cond_en(count_condition_enable_q),
    .events(events),
    .step(step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  assign do_inc = run & step.inc; // RULE1 RULE10
  assign do_dec = run & step.dec; // RULE1 RULE10
  assign ovf = do_inc & (&up_down_counter_q); // RULE8
  assign udf = do_dec & ~(|up_down_counter_q); // RULE8
  // CLR_NONE and CLR_OFF never clear the counter
  assign auto_clr = run & ((clr_sel == quadrature_phase_counter_pkg::CLR_A_RISE
                            & filt.a & ~prev_q.a) |
                           (clr_sel == quadrature_phase_counter_pkg::CLR_B_RISE
                            & filt.b & ~prev_q.b)); // RULE5

  always_comb
  begin
    up_down_counter_d = up_down_counter_q;
    if (wr_cnt)
      up_down_counter_d = pwdata[CNT_W-1:0]; // RULE7
    else if (auto_clr)
      up_down_counter_d = '0;
    else if (do_inc)
      up_down_counter_d = up_down_counter_q + CNT_W'(1); // RULE2
    else if (do_dec)
      up_down_counter_d = up_down_counter_q - CNT_W'(1); // RULE3
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_down_counter_q <= CNT_W'(quadrature_phase_counter_pkg::CNT_RST);
    else if (timer_rst)
      up_down_counter_q <= CNT_W'(quadrature_phase_counter_pkg::CNT_RST); // RULE9
    else
      up_down_counter_q <= up_down_counter_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, request flag and interrupt, set wins over clear
  assign stat_set = {udf & ~wr_cnt, ovf & ~wr_cnt};
  assign flag_set = |(stat_set & mask_q); // RULE11

  always_comb
  begin
    stat_d = stat_q;
    flag_d = timer_irq_request_flag_q;
    if (wr_stat)
      stat_d = stat_q & ~pwdata[1:0];
    stat_d = stat_d | stat_set; // RULE8
    if (wr_flag & pwdata[quadrature_phase_counter_pkg::FLAG_BIT])
      flag_d = 1'b0;
    flag_d = flag_d | flag_set; // RULE11
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= quadrature_phase_counter_pkg::STAT_RST;
      timer_irq_request_flag_q <= 1'b0;
    end
    else if (timer_rst)
    begin
      stat_q <= quadrature_phase_counter_pkg::STAT_RST;
      timer_irq_request_flag_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      timer_irq_request_flag_q <= flag_d;
    end
  end

  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_inc_step;
    gate_q && run && step.inc && !wr_cnt && !auto_clr
      |=> up_down_counter_q == $past(up_down_counter_q) + CNT_W'(1);
  endproperty
  a_inc_step: assert property (p_inc_step) else $error("count did not rise"); // RULE2

  property p_dec_step;
    gate_q && run && step.dec && !wr_cnt && !auto_clr
      |=> up_down_counter_q == $past(up_down_counter_q) - CNT_W'(1);
  endproperty
  a_dec_step: assert property (p_dec_step) else $error("count did not fall"); // RULE3

  property p_cond_gate;
    step.inc |-> |(events[7:4] & count_condition_enable_q[7:4]);
  endproperty
  a_cond_gate: assert property (p_cond_gate) else $error("disabled event stepped"); // RULE4

  property p_stopped;
    gate_q && !run && !wr_cnt |=> up_down_counter_q == $past(up_down_counter_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // RULE10

  property p_gated_off;
    !gate_q && !(wr_acc && hit_gate) |=> !gate_q && up_down_counter_q == '0 && mode_q == 8'h00
      && !timer_irq_request_flag_q;
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("timer not held in reset"); // RULE9

  property p_start_value;
    wr_cnt |=> up_down_counter_q == $past(pwdata[CNT_W-1:0]);
  endproperty
  a_start_value: assert property (p_start_value) else $error("start value lost"); // RULE7

  property p_overflow;
    gate_q && do_inc && (&up_down_counter_q) && !wr_cnt
      |=> stat_q[quadrature_phase_counter_pkg::STAT_OVF_BIT] && up_down_counter_q == '0;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow missed"); // RULE8

  property p_flag_hold;
    timer_irq_request_flag_q && gate_q && !(wr_flag && pwdata[0]) |=> timer_irq_request_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("request flag dropped"); // RULE11

  property p_one_step;
    !(step.inc && step.dec);
  endproperty
  a_one_step: assert property (p_one_step) else $error("two steps at once"); // RULE12

  property p_bypass;
    !filt_en[0] |-> filt.a == sync2_q.a;
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed"); // RULE6

  property p_no_clear;
    gate_q && clr_sel == quadrature_phase_counter_pkg::CLR_NONE |-> !auto_clr;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("counter cleared"); // RULE5

  c_up: cover property (gate_q && do_inc);
  c_down: cover property (gate_q && do_dec);
  c_wrap: cover property (gate_q && udf ##1 irq);

endmodule // quadrature_phase_counter

// ==== hw/quadrature_phase_counter_pkg.sv ====
// Shared constants and carrier types of the quadrature phase counter
package quadrature_phase_counter_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_GATE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COND = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int GATE_BIT = 0;
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_CLR_HI = 6;
  localparam int MODE_CLR_LO = 5;
  localparam int MODE_FILT_B_BIT = 3;
  localparam int MODE_FILT_A_BIT = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UDF_BIT = 1;
  localparam int FLAG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COND_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam int FILT_LEN_DEF = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Clear source selection
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_A_RISE = 2'h1,
    CLR_B_RISE = 2'h2,
    CLR_OFF = 2'h3
  } clr_sel_t;

  // Phase input pair and one counting step
  typedef struct packed {
    logic b;
    logic a;
  } phase_pair_t;

  typedef struct packed {
    logic inc;
    logic dec;
  } step_t;

endpackage

// ==== testbench/quad_source.sv ====
// Behavioural two-phase quadrature source driving pins A and B
`timescale 1ns/1ns
module quad_source #(
  parameter int HOLD = 8
) (
  input wire logic pclk,
  output logic phase_input_a,
  output logic phase_input_b
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;

  assign phase_input_a = a_q;
  assign phase_input_b = b_q;

  ////////////////////////////////////////////////////////////////////////////
  // One quarter step per call unit, each level held HOLD + 1 cycles
  task automatic move(input bit up, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (up == (a_q == b_q))
        b_q <= ~b_q;
      else
        a_q <= ~a_q;
      repeat (HOLD) @(posedge pclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulse on A, too short for the filter
  task automatic glitch;
    @(posedge pclk);
    a_q <= ~a_q;
    @(posedge pclk);
    a_q <= ~a_q;
    repeat (HOLD) @(posedge pclk);
  endtask
endmodule // quad_source

// ==== testbench/quadrature_phase_counter_tb.sv ====
// Self-checking bench for the quadrature phase counter
`timescale 1ns/1ns
module quadrature_phase_counter_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic phase_input_a;
  logic phase_input_b;
  logic irq;
  logic [31:0] rdata;
  logic err;
  int n_fail;
  int total_checks;
  int i;

  quadrature_phase_counter #(.CNT_W(16), .FILT_LEN(3)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .phase_input_a(phase_input_a),
    .phase_input_b(phase_input_b),
    .irq(irq)
  );

  quad_source #(.HOLD(8)) u_src (
    .pclk(pclk),
    .phase_input_a(phase_input_a),
    .phase_input_b(phase_input_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    irq_chk(1'b0);
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'h80);
    rd_chk(quadrature_phase_counter_pkg::OFS_GATE, 32'h0);
    wr(quadrature_phase_counter_pkg::OFS_GATE, 32'h1);
    rd_chk(quadrature_phase_counter_pkg::OFS_MODE, 32'h0);
    rd_chk(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Start value, run bit off then on
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h1234);
    wr(quadrature_phase_counter_pkg::OFS_COND, 32'hff);
    u_src.move(1'b1, 4);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h1234);
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'h80);
    repeat (10) @(posedge pclk);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h1234);
    u_src.move(1'b1, 4);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h1238);
    // Each condition enabled alone over a full cycle up and down
    for (i = 0; i < 8; i++)
    begin
      wr(quadrature_phase_counter_pkg::OFS_COND, 32'h1 << i);
      wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h0);
      u_src.move(1'b1, 4);
      u_src.move(1'b0, 4);
      rd_chk(quadrature_phase_counter_pkg::OFS_CNT, i > 3 ? 32'h1 : 32'hffff);
    end
    // Overflow, underflow, mask and request flag
    wr(quadrature_phase_counter_pkg::OFS_STAT, 32'h3);
    wr(quadrature_phase_counter_pkg::OFS_FLAG, 32'h1);
    wr(quadrature_phase_counter_pkg::OFS_MASK, 32'h1);
    wr(quadrature_phase_counter_pkg::OFS_COND, 32'hff);
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'he0);
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'hffff);
    u_src.move(1'b1, 1);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h0);
    rd_chk(quadrature_phase_counter_pkg::OFS_STAT, 32'h1);
    irq_chk(1'b1);
    rd_chk(quadrature_phase_counter_pkg::OFS_FLAG, 32'h1);
    wr(quadrature_phase_counter_pkg::OFS_STAT, 32'h1);
    irq_chk(1'b0);
    rd_chk(quadrature_phase_counter_pkg::OFS_FLAG, 32'h1);
    wr(quadrature_phase_counter_pkg::OFS_FLAG, 32'h1);
    rd_chk(quadrature_phase_counter_pkg::OFS_FLAG, 32'h0);
    u_src.move(1'b0, 1);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'hffff);
    rd_chk(quadrature_phase_counter_pkg::OFS_STAT, 32'h2);
    irq_chk(1'b0);
    rd_chk(quadrature_phase_counter_pkg::OFS_FLAG, 32'h0);
    wr(quadrature_phase_counter_pkg::OFS_MASK, 32'h3);
    irq_chk(1'b1);
    wr(quadrature_phase_counter_pkg::OFS_STAT, 32'h2);
    irq_chk(1'b0);
    // Short pulse on A passes unfiltered, is rejected when filtered
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'h80);
    wr(quadrature_phase_counter_pkg::OFS_COND, 32'h02);
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h10);
    u_src.glitch;
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'hf);
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'h8c);
    u_src.glitch;
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'hf);
    wr(quadrature_phase_counter_pkg::OFS_COND, 32'hff);
    u_src.move(1'b1, 4);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h13);
    // Clear on A rise, then clear on B rise, overrides the step of that edge
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'ha0);
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h40);
    u_src.move(1'b1, 4);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h2);
    wr(quadrature_phase_counter_pkg::OFS_MODE, 32'hc0);
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h40);
    u_src.move(1'b1, 4);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h3);
    // Gate off holds the timer in reset
    wr(quadrature_phase_counter_pkg::OFS_GATE, 32'h0);
    wr(quadrature_phase_counter_pkg::OFS_CNT, 32'h55);
    wr(quadrature_phase_counter_pkg::OFS_GATE, 32'h1);
    rd_chk(quadrature_phase_counter_pkg::OFS_CNT, 32'h0);
    rd_chk(quadrature_phase_counter_pkg::OFS_MODE, 32'h0);
    rd_chk(quadrature_phase_counter_pkg::OFS_COND, 32'h0);
    stop_test;
  end
endmodule // quadrature_phase_counter_tb
